// ### hps_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// photovoltaic harvester seen from the supervisor
// ====================================================
module hps_partner (
	input wire logic clk,
	input wire logic slow,
	input wire logic source_isolation_switch,
	input wire logic [12:0] regulation_target_voltage,
	input wire logic [12:0] voc_mv,
	output logic [12:0] harvester_input_mv
);
	logic [12:0] settle_reg;
	logic [12:0] level;
	// loaded cell sits at the target, an open one rises to voc
	assign level = source_isolation_switch ? regulation_target_voltage : voc_mv;
	// slow cells need two cycles to settle, still inside the open window
	always_ff @(posedge clk) begin
		settle_reg <= level;
		harvester_input_mv <= slow ? settle_reg : level;
	end
endmodule : hps_partner
`default_nettype wire

// ### hps_pkg.sv
package hps_pkg;
	// =====================================================================
	// time base
	// =====================================================================
	localparam int unsigned HPS_CLK_HZ = 25000000;
	localparam int unsigned HPS_TICK_US = 10000;
	localparam int unsigned HPS_TICK_CYC = HPS_CLK_HZ / 1000000 * HPS_TICK_US;
	// =====================================================================
	// periods in ms, converted to ticks of 10 ms (rounded down)
	// =====================================================================
	localparam int unsigned HPS_STO_SUPPLY_MS = 120;
	localparam int unsigned HPS_STO_SLEEP_MS = 960;
	localparam int unsigned HPS_GPIO_MS = 1920;
	localparam int unsigned HPS_TEMP_MS = 7670;
	localparam int unsigned HPS_CRIT_MS = 2500;
	localparam int unsigned HPS_STO_SUPPLY_TK = HPS_STO_SUPPLY_MS * 1000 / HPS_TICK_US;
	localparam int unsigned HPS_STO_SLEEP_TK = HPS_STO_SLEEP_MS * 1000 / HPS_TICK_US;
	localparam int unsigned HPS_GPIO_TK = HPS_GPIO_MS * 1000 / HPS_TICK_US;
	localparam int unsigned HPS_TEMP_TK = HPS_TEMP_MS * 1000 / HPS_TICK_US;
	localparam int unsigned HPS_CRIT_TK = HPS_CRIT_MS * 1000 / HPS_TICK_US;
	// =====================================================================
	// tracking timings (ms): open-circuit time and period
	// =====================================================================
	localparam int unsigned HPS_VOC_MS_DEF = 2;
	localparam int unsigned HPS_MPPT_MS_DEF = 256;
	// =====================================================================
	// voltage codes: mV
	// =====================================================================
	localparam logic [12:0] HPS_INTERNAL_SUPPLY_START_MV = 13'h08FC; // 2300
	localparam logic [12:0] HPS_OVCH_MIN_MV = 13'h0BB8; // 3000
	localparam logic [12:0] HPS_OVCH_MAX_MV = 13'h12C0; // 4800
	localparam logic [12:0] HPS_OVDIS_MIN_MV = 13'h0AF0; // 2800
	localparam logic [12:0] HPS_OVDIS_MAX_MV = 13'h0FD2; // 4050
	localparam logic [12:0] HPS_MPP_MIN_MV = 13'h0078; // 120
	localparam logic [12:0] HPS_MPP_MAX_MV = 13'h05BE; // 1470
	localparam logic [12:0] HPS_TH_SPAN_MV = 13'h03E8; // 1000
	localparam int unsigned HPS_RATIO_N = 9;
	localparam logic [3:0] HPS_RATIO_RESET = 4'h7;
	localparam logic HPS_HP_ALLOW_RESET = 1'b1;

	typedef enum logic [7:0] {
		HPS_ST_RESET = 8'h01,
		HPS_ST_SENSE_SRC = 8'h02,
		HPS_ST_SENSE_STO = 8'h04,
		HPS_ST_SUPPLY = 8'h08,
		HPS_ST_SLEEP = 8'h10,
		HPS_ST_SHUTDOWN = 8'h20,
		HPS_ST_OVDIS = 8'h40
	} hps_state_t;
endpackage : hps_pkg

// ### hps_supervisor.sv
// Notes on behaviour
// - each period: isolate source, settle, sample
// - tracking runs in all states but reset
// - storage check 0.12 s supply, 0.96 s sleep
// - configuration pins sampled every 1.92 s
// - temperature evaluated every 7.67 s
// - 2.50 s low in shutdown: overdischarge
// - charging stops at overcharge, 3-4.8 V
// - overdischarge threshold 2.8-4.05 V
// - no keep-alive: internal switch until recovered
// - keep-alive: battery feeds supply while storage is above overdischarge, never internal
// - temperature out of range inhibits charge, flags
// - thermistor input span 0 to 1 V
// - enough source energy: high-power mode
// - high power allowed from reset, host disables
// - no keep-alive, weak source: reset state
// - keep-alive holds supply above overdischarge
// - target 0.12-1.47 V, nine ratios
// - supply at 2.3 V: latch pins, sense source
// - after storage sensing go to supply
// - leave sleep on source rise or disable
`timescale 1ns/1ps
`default_nettype none
module hps_supervisor import hps_pkg::*; #(
	parameter int unsigned TICK_CYC = HPS_TICK_CYC,
	parameter int unsigned VOC_CYC = HPS_VOC_MS_DEF * HPS_CLK_HZ / 1000,
	parameter int unsigned MPPT_TK = HPS_MPPT_MS_DEF * 1000 / HPS_TICK_US
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [12:0] internal_supply_mv,
	input wire logic [12:0] storage_node_mv,
	input wire logic [12:0] harvester_input_mv,
	input wire logic [12:0] thermistor_sense_pin_mv,
	input wire logic [12:0] temp_low_mv,
	input wire logic [12:0] temp_high_mv,
	input wire logic [12:0] overcharge_threshold,
	input wire logic [12:0] overdischarge_threshold,
	input wire logic [12:0] sleep_source_threshold,
	input wire logic [3:0] ratio_sel,
	input wire logic [7:0] cfg_pins,
	input wire logic keep_alive,
	input wire logic sleep_enable,
	input wire logic shutdown_req,
	input wire logic high_power_allow,
	input wire logic high_power_level,
	input wire logic source_weak,
	input wire logic internal_supply_recovered,
	output logic source_isolation_switch,
	output logic internal_highside_switch,
	output logic storage_highside_switch,
	output logic battery_to_internal_switch,
	output logic charge_enable,
	output logic high_power_mode,
	output logic temp_flag,
	output logic [12:0] regulation_target_voltage,
	output logic [7:0] cfg_latched,
	output logic [7:0] state_code
);
	typedef struct packed {
		hps_state_t st;
		logic [31:0] voc_cnt;
		logic [15:0] mppt_tk;
		logic [15:0] sto_tk;
		logic [15:0] gpio_tk;
		logic [15:0] temp_tk;
		logic [15:0] crit_tk;
		logic isolate;
		logic use_int;
		logic sto_ok;
		logic sto_full;
		logic temp_bad;
		logic hp;
		logic [12:0] target;
		logic [7:0] cfg;
	} hps_sv_t;
	hps_sv_t s_reg, s_next;
	logic tick;

	hps_timebase #(.TICK_CYC(TICK_CYC)) u_tb (
		.clk(clk),
		.arst_n(arst_n),
		.tick(tick)
	);

	// =====================================================================
	// helpers
	// =====================================================================
	function automatic logic [12:0] hps_clamp(input logic [12:0] v,
		input logic [12:0] lo, input logic [12:0] hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction : hps_clamp

	// ratio in percent: 35, 50, 60..90 by 5
	function automatic logic [6:0] hps_ratio(input logic [3:0] sel);
		logic [6:0] r;
		case (sel)
			4'h0: r = 7'h23;
			4'h1: r = 7'h32;
			4'h2: r = 7'h3C;
			4'h3: r = 7'h41;
			4'h4: r = 7'h46;
			4'h5: r = 7'h4B;
			4'h6: r = 7'h50;
			4'h7: r = 7'h55;
			4'h8: r = 7'h5A;
			default: r = 7'h50;
		endcase
		return r;
	endfunction : hps_ratio

	function automatic logic [15:0] hps_dec(input logic [15:0] c,
		input logic t);
		return (t && c != 16'h0000) ? c - 16'h0001 : c;
	endfunction : hps_dec

	logic [12:0] ovch_eff, ovdis_eff, th_clip;
	logic [19:0] target_prod;
	always_comb begin
		ovch_eff = hps_clamp(overcharge_threshold, HPS_OVCH_MIN_MV,
			HPS_OVCH_MAX_MV);
		ovdis_eff = hps_clamp(overdischarge_threshold, HPS_OVDIS_MIN_MV,
			HPS_OVDIS_MAX_MV);
		th_clip = hps_clamp(thermistor_sense_pin_mv, 13'h0000,
			HPS_TH_SPAN_MV);
		target_prod = 20'(harvester_input_mv * hps_ratio(ratio_sel)
			/ 7'h64);
	end

	// =====================================================================
	// state machine and schedules
	// =====================================================================
	always_comb begin
		s_next = s_reg;
		s_next.sto_tk = hps_dec(s_reg.sto_tk, tick);
		s_next.gpio_tk = hps_dec(s_reg.gpio_tk, tick);
		s_next.temp_tk = hps_dec(s_reg.temp_tk, tick);
		s_next.mppt_tk = hps_dec(s_reg.mppt_tk, tick);
		// tracking, active outside reset
		if (s_reg.st != HPS_ST_RESET) begin
			if (s_reg.isolate) begin
				if (s_reg.voc_cnt >= VOC_CYC - 1) begin
					s_next.isolate = 1'b0;
					s_next.voc_cnt = '0;
					s_next.target = hps_clamp(target_prod[12:0],
						HPS_MPP_MIN_MV, HPS_MPP_MAX_MV);
					s_next.mppt_tk = 16'(MPPT_TK);
				end else begin
					s_next.voc_cnt = s_reg.voc_cnt + 32'h00000001;
				end
			end else if (s_reg.mppt_tk == 16'h0000) begin
				s_next.isolate = 1'b1;
			end
		end
		if (s_reg.gpio_tk == 16'h0000 && s_reg.st != HPS_ST_RESET) begin
			s_next.cfg = cfg_pins;
			s_next.gpio_tk = 16'(HPS_GPIO_TK);
		end
		if (s_reg.temp_tk == 16'h0000 && s_reg.st != HPS_ST_RESET) begin
			s_next.temp_bad = th_clip < temp_low_mv
				|| th_clip > temp_high_mv;
			s_next.temp_tk = 16'(HPS_TEMP_TK);
		end
		if (s_reg.sto_tk == 16'h0000) begin
			s_next.sto_full = storage_node_mv >= ovch_eff;
			s_next.sto_ok = storage_node_mv > ovdis_eff;
			s_next.sto_tk = 16'(s_reg.st == HPS_ST_SLEEP ?
				HPS_STO_SLEEP_TK : HPS_STO_SUPPLY_TK);
		end
		s_next.hp = high_power_allow && high_power_level
			&& s_reg.st != HPS_ST_RESET;
		if (keep_alive) begin
			s_next.use_int = 1'b0;
		end else if (!internal_supply_recovered) begin
			s_next.use_int = 1'b1;
		end else if (internal_supply_recovered) begin
			s_next.use_int = 1'b0;
		end
		case (s_reg.st)
			HPS_ST_RESET: begin
				s_next.isolate = 1'b0;
				if (internal_supply_mv >= HPS_INTERNAL_SUPPLY_START_MV) begin
					s_next.cfg = cfg_pins;
					s_next.gpio_tk = 16'(HPS_GPIO_TK);
					s_next.st = HPS_ST_SENSE_SRC;
				end
			end
			HPS_ST_SENSE_SRC: begin
				if (s_reg.isolate && s_reg.voc_cnt >= VOC_CYC - 1) begin
					s_next.st = HPS_ST_SENSE_STO;
				end
			end
			HPS_ST_SENSE_STO: begin
				s_next.sto_full = storage_node_mv >= ovch_eff;
				s_next.sto_ok = storage_node_mv > ovdis_eff;
				s_next.temp_bad = th_clip < temp_low_mv
					|| th_clip > temp_high_mv;
				s_next.sto_tk = 16'(HPS_STO_SUPPLY_TK);
				s_next.temp_tk = 16'(HPS_TEMP_TK);
				s_next.st = HPS_ST_SUPPLY;
			end
			HPS_ST_SUPPLY, HPS_ST_SLEEP: begin
				if (s_reg.st == HPS_ST_SUPPLY && sleep_enable
					&& s_reg.target < sleep_source_threshold) begin
					s_next.st = HPS_ST_SLEEP;
				end
				if (s_reg.st == HPS_ST_SLEEP && (!sleep_enable
					|| s_reg.target >= sleep_source_threshold)) begin
					s_next.st = HPS_ST_SUPPLY;
				end
				if (shutdown_req) begin
					s_next.st = HPS_ST_SHUTDOWN;
					s_next.crit_tk = 16'(HPS_CRIT_TK);
				end
			end
			HPS_ST_SHUTDOWN: begin
				if (storage_node_mv >= ovdis_eff) begin
					s_next.crit_tk = 16'(HPS_CRIT_TK);
					if (!shutdown_req) begin
						s_next.st = HPS_ST_SUPPLY;
					end
				end else if (s_reg.crit_tk == 16'h0000) begin
					s_next.st = HPS_ST_OVDIS;
				end else begin
					s_next.crit_tk = hps_dec(s_reg.crit_tk, tick);
				end
			end
			HPS_ST_OVDIS: begin
				if (storage_node_mv > ovdis_eff) begin
					s_next.st = HPS_ST_SUPPLY;
				end
			end
			default: s_next.st = HPS_ST_RESET;
		endcase
		// supply loss: keep-alive survives while the battery holds
		if (s_reg.st != HPS_ST_RESET) begin
			if (!keep_alive && source_weak) begin
				s_next.st = HPS_ST_RESET;
			end else if (keep_alive && source_weak
				&& !s_reg.sto_ok) begin
				s_next.st = HPS_ST_RESET;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '{st: HPS_ST_RESET, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	// =====================================================================
	// outputs
	// =====================================================================
	// isolation switch closed (conducting) unless sampling open circuit or in reset
	assign source_isolation_switch = !s_reg.isolate
		&& s_reg.st != HPS_ST_RESET;
	assign internal_highside_switch = s_reg.use_int && !keep_alive;
	assign storage_highside_switch = !internal_highside_switch
		&& charge_enable;
	assign battery_to_internal_switch = keep_alive
		&& s_reg.sto_ok;
	assign charge_enable = !s_reg.sto_full && !s_reg.temp_bad
		&& (s_reg.st == HPS_ST_SUPPLY || s_reg.st == HPS_ST_SLEEP);
	assign high_power_mode = s_reg.hp;
	assign temp_flag = s_reg.temp_bad;
	assign regulation_target_voltage = s_reg.target;
	assign cfg_latched = s_reg.cfg;
	assign state_code = s_reg.st;

	// =====================================================================
	// checks
	// =====================================================================
	property p_hp_gated;
		@(posedge clk) disable iff (!arst_n)
		!high_power_allow |=> !high_power_mode;
	endproperty
	a_hp_gated: assert property (p_hp_gated)
		else $error("high power without allow");
	property p_ka_no_int;
		@(posedge clk) disable iff (!arst_n)
		keep_alive |-> !internal_highside_switch ##1 !s_reg.use_int;
	endproperty
	a_ka_no_int: assert property (p_ka_no_int)
		else $error("internal switch used under keep-alive");
	property p_temp_inhibit;
		@(posedge clk) disable iff (!arst_n)
		temp_flag |-> !charge_enable;
	endproperty
	a_temp_inhibit: assert property (p_temp_inhibit)
		else $error("charging while temperature out of range");
	property p_reset_no_track;
		@(posedge clk) disable iff (!arst_n)
		s_reg.st == HPS_ST_RESET && $past(s_reg.st) == HPS_ST_RESET
			|-> !s_reg.isolate;
	endproperty
	a_reset_no_track: assert property (p_reset_no_track)
		else $error("tracking active in reset");
	property p_weak_reset;
		@(posedge clk) disable iff (!arst_n)
		s_reg.st != HPS_ST_RESET && !keep_alive && source_weak
			|=> s_reg.st == HPS_ST_RESET;
	endproperty
	a_weak_reset: assert property (p_weak_reset)
		else $error("no reset on weak source");
	property p_sense_sto;
		@(posedge clk) disable iff (!arst_n)
		s_reg.st == HPS_ST_SENSE_STO && !source_weak
			|=> s_reg.st == HPS_ST_SUPPLY;
	endproperty
	a_sense_sto: assert property (p_sense_sto)
		else $error("storage sensing did not end in supply");
	property p_start;
		@(posedge clk) disable iff (!arst_n)
		s_reg.st == HPS_ST_RESET && internal_supply_mv >= HPS_INTERNAL_SUPPLY_START_MV
			|=> s_reg.st == HPS_ST_SENSE_SRC && cfg_latched == $past(cfg_pins);
	endproperty
	a_start: assert property (p_start)
		else $error("start did not latch pins");
	property p_target_range;
		@(posedge clk) disable iff (!arst_n)
		$changed(regulation_target_voltage) |-> regulation_target_voltage
			>= HPS_MPP_MIN_MV && regulation_target_voltage <= HPS_MPP_MAX_MV;
	endproperty
	a_target_range: assert property (p_target_range)
		else $error("target out of range");
	c_sleep: cover property (@(posedge clk) s_reg.st == HPS_ST_SLEEP);
	c_ovdis: cover property (@(posedge clk) s_reg.st == HPS_ST_OVDIS);
	c_sample: cover property (@(posedge clk) $fell(s_reg.isolate));
endmodule : hps_supervisor
`default_nettype wire

// ### hps_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module hps_timebase import hps_pkg::*; #(
	parameter int unsigned TICK_CYC = HPS_TICK_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	output logic tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} hps_tb_t;
	hps_tb_t s_reg, s_next;
	// =====================================================================
	// shared tick for every period
	// =====================================================================
	always_comb begin
		s_next = s_reg;
		s_next.tick = 1'b0;
		if (s_reg.cnt >= TICK_CYC - 1) begin
			s_next.cnt = '0;
			s_next.tick = 1'b1;
		end else begin
			s_next.cnt = s_reg.cnt + 32'h00000001;
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
	assign tick = s_reg.tick;
endmodule : hps_timebase
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import hps_pkg::*;;
	// ====================================================
	// shortened counts, expectations derive from these
	// ====================================================
	localparam int TICK = 4;
	localparam int VOC = 3;
	localparam int ISO = 0;
	localparam int CHG = 1;
	localparam int TMP = 2;
	localparam int HPM = 3;
	logic clk, arst_n, keep_alive, sleep_enable, shutdown_req, slow;
	logic high_power_allow, high_power_level, source_weak, internal_supply_recovered;
	logic [12:0] internal_supply_mv, storage_node_mv, harvester_input_mv;
	logic [12:0] thermistor_sense_pin_mv, temp_low_mv, temp_high_mv, voc_mv;
	logic [12:0] overcharge_threshold, overdischarge_threshold;
	logic [12:0] sleep_source_threshold, regulation_target_voltage;
	logic [3:0] ratio_sel;
	logic [7:0] cfg_pins, cfg_latched, state_code;
	logic source_isolation_switch, internal_highside_switch;
	logic storage_highside_switch, battery_to_internal_switch;
	logic charge_enable, high_power_mode, temp_flag;
	int failures, compares, cycles, n;
	hps_supervisor #(.TICK_CYC(TICK), .VOC_CYC(VOC), .MPPT_TK(2))
		hps_supervisor_i (
		.clk, .arst_n, .internal_supply_mv, .storage_node_mv,
		.harvester_input_mv, .thermistor_sense_pin_mv, .temp_low_mv,
		.temp_high_mv, .overcharge_threshold, .overdischarge_threshold,
		.sleep_source_threshold, .ratio_sel, .cfg_pins, .keep_alive,
		.sleep_enable, .shutdown_req, .high_power_allow, .high_power_level,
		.source_weak, .internal_supply_recovered, .source_isolation_switch,
		.internal_highside_switch, .storage_highside_switch,
		.battery_to_internal_switch, .charge_enable, .high_power_mode,
		.temp_flag, .regulation_target_voltage, .cfg_latched, .state_code
	);
	hps_partner hps_partner_i (.clk, .slow, .source_isolation_switch,
		.regulation_target_voltage, .voc_mv, .harvester_input_mv);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ====================================================
	// checking helpers
	// ====================================================
	task automatic chk_bit(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit
	task automatic chk_val(input string what, input logic [12:0] exp,
		input logic [12:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_val
	function automatic logic pick(input int s);
		case (s)
			ISO: return source_isolation_switch;
			CHG: return charge_enable;
			TMP: return temp_flag;
			default: return high_power_mode;
		endcase
	endfunction : pick
	task automatic wait_out(input int s, input logic lvl, input int max);
		for (n = 0; n < max && pick(s) !== lvl; n++) begin
			@(negedge clk);
		end
		chk_bit($sformatf("output %0d", s), lvl, pick(s));
	endtask : wait_out
	task automatic wait_state(input logic [7:0] code, input int max);
		for (n = 0; n < max && state_code !== code; n++) begin
			@(negedge clk);
		end
		chk_val("state_code", {5'h00, code}, {5'h00, state_code});
	endtask : wait_state
	task automatic end_test(input string name);
		$display("test %s done, failures so far %0d", name, failures);
	endtask : end_test
	// ====================================================
	// bring-up, every test starts from a cold start
	// ====================================================
	task automatic power_up(input logic [7:0] pins);
		arst_n = 1'b0;
		internal_supply_mv = 13'h0000;
		storage_node_mv = 13'h0DAC;
		voc_mv = 13'h03E8;
		thermistor_sense_pin_mv = 13'h01F4;
		temp_low_mv = 13'h0064;
		temp_high_mv = 13'h0384;
		overcharge_threshold = 13'h0FA0;
		overdischarge_threshold = 13'h0BB8;
		sleep_source_threshold = 13'h0064;
		ratio_sel = 4'h4;
		cfg_pins = pins;
		{keep_alive, sleep_enable, shutdown_req, slow} = 4'h0;
		high_power_allow = 1'b1;
		{high_power_level, source_weak, internal_supply_recovered} = 3'h1;
		repeat (10) @(negedge clk);
		arst_n = 1'b1;
		repeat (20) @(negedge clk);
		chk_val("reset_state", 13'h0001, {5'h00, state_code});
		chk_bit("reset_isolation", 1'b0, source_isolation_switch);
		chk_val("reset_target", 13'h0000, regulation_target_voltage);
		internal_supply_mv = HPS_INTERNAL_SUPPLY_START_MV;
		wait_state(8'h02, 5);
		chk_val("cfg_latched", {5'h00, pins}, {5'h00, cfg_latched});
		wait_state(8'h08, 40);
		chk_val("first_target", 13'h02BC, regulation_target_voltage);
	endtask : power_up
	// one whole tracking cycle, new settings land before it opens
	task automatic track(input logic [3:0] sel, input logic [12:0] v,
		input logic [12:0] exp);
		ratio_sel = sel;
		voc_mv = v;
		wait_out(ISO, 1'b1, 40);
		wait_out(ISO, 1'b0, 40);
		wait_out(ISO, 1'b1, 40);
		chk_val("open_cycles", 13'(VOC), 13'(n));
		@(negedge clk);
		chk_val("target", exp, regulation_target_voltage);
	endtask : track
	// ====================================================
	// scenarios
	// ====================================================
	task automatic t_ratios;
		int pct [10] = '{35, 50, 60, 65, 70, 75, 80, 85, 90, 80};
		power_up(8'hA5);
		for (int i = 0; i < 10; i++) begin
			slow = i[0];
			track((i == 9) ? 4'hF : 4'(i), 13'h03E8, 13'(10 * pct[i]));
		end
		track(4'h8, 13'h0708, HPS_MPP_MAX_MV);
		track(4'h0, 13'h00C8, HPS_MPP_MIN_MV);
		end_test("ratios");
	endtask : t_ratios
	task automatic t_supply_paths;
		power_up(8'h5A);
		internal_supply_recovered = 1'b0;
		repeat (3) @(negedge clk);
		chk_bit("internal_hs", 1'b1, internal_highside_switch);
		chk_bit("storage_hs", 1'b0, storage_highside_switch);
		internal_supply_recovered = 1'b1;
		repeat (3) @(negedge clk);
		chk_bit("internal_hs", 1'b0, internal_highside_switch);
		chk_bit("storage_hs", 1'b1, storage_highside_switch);
		{keep_alive, internal_supply_recovered, source_weak} = 3'h5;
		repeat (60) @(negedge clk);
		chk_bit("internal_hs", 1'b0, internal_highside_switch);
		chk_bit("batt_to_int", 1'b1, battery_to_internal_switch);
		chk_val("kept_state", 13'h0008, {5'h00, state_code});
		overdischarge_threshold = 13'h07D0;
		storage_node_mv = 13'h0B54;
		repeat (60) @(negedge clk);
		chk_val("clamped_ovdis", 13'h0008, {5'h00, state_code});
		storage_node_mv = 13'h0A8C;
		wait_state(8'h01, 12 * TICK + 8);
		power_up(8'h5A);
		source_weak = 1'b1;
		wait_state(8'h01, 10);
		end_test("supply_paths");
	endtask : t_supply_paths
	task automatic t_charge_temp;
		power_up(8'h3C);
		wait_out(CHG, 1'b1, 60);
		storage_node_mv = 13'h0FA0;
		wait_out(CHG, 1'b0, 12 * TICK + 8);
		storage_node_mv = 13'h0DAC;
		wait_out(CHG, 1'b1, 12 * TICK + 8);
		overcharge_threshold = 13'h07D0;
		storage_node_mv = 13'h0C1C;
		wait_out(CHG, 1'b0, 12 * TICK + 8);
		overcharge_threshold = 13'h0FA0;
		thermistor_sense_pin_mv = 13'h03B6;
		wait_out(TMP, 1'b1, 767 * TICK + 8);
		wait_out(CHG, 1'b0, 2);
		// above the adc span the reading pins at full scale
		temp_low_mv = 13'h03B6;
		temp_high_mv = 13'h04B0;
		thermistor_sense_pin_mv = 13'h0514;
		wait_out(TMP, 1'b0, 767 * TICK + 8);
		wait_out(CHG, 1'b1, 12 * TICK + 8);
		end_test("charge_temp");
	endtask : t_charge_temp
	task automatic t_power_pins;
		int k;
		power_up(8'hA5);
		high_power_level = 1'b1;
		wait_out(HPM, 1'b1, 20);
		high_power_allow = 1'b0;
		wait_out(HPM, 1'b0, 20);
		k = 0;
		repeat (40) begin
			@(negedge clk);
			k += int'(high_power_mode !== 1'b0);
		end
		chk_val("hp_blocked", 13'h0000, 13'(k));
		cfg_pins = 8'h96;
		for (n = 0; n < 192 * TICK + 8 && cfg_latched !== 8'h96; n++) begin
			@(negedge clk);
		end
		chk_val("cfg_resampled", 13'h0096, {5'h00, cfg_latched});
		end_test("power_pins");
	endtask : t_power_pins
	task automatic t_sleep;
		power_up(8'hC3);
		sleep_source_threshold = 13'h0320;
		sleep_enable = 1'b1;
		wait_state(8'h10, 40);
		track(4'h4, 13'h03E8, 13'h02BC);
		track(4'h4, 13'h0578, 13'h03D4);
		wait_state(8'h08, 20);
		sleep_source_threshold = 13'h04B0;
		wait_state(8'h10, 40);
		sleep_enable = 1'b0;
		wait_state(8'h08, 10);
		end_test("sleep");
	endtask : t_sleep
	task automatic t_critical;
		power_up(8'h0F);
		storage_node_mv = 13'h09C4;
		repeat (60) @(negedge clk);
		shutdown_req = 1'b1;
		wait_state(8'h20, 10);
		for (n = 0; n < 1300 && state_code === 8'h20; n++) begin
			@(negedge clk);
		end
		chk_val("dwell_end", 13'h0040, {5'h00, state_code});
		chk_bit("dwell_len", 1'b1, n >= 250 * TICK - 8 && n <= 250 * TICK + 8);
		end_test("critical");
	endtask : t_critical
	// ====================================================
	// run control
	// ====================================================
	task automatic tally_and_finish;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	// whole run is near 9k cycles, so this only trips on a hang
	always @(posedge clk) begin
		cycles++;
		if (cycles > 40000) begin
			failures++;
			$display("wrong value cycle_limit expected end seen hang");
			tally_and_finish;
		end
	end
	initial begin
		{failures, compares, cycles} = '0;
		t_ratios;
		t_supply_paths;
		t_charge_temp;
		t_power_pins;
		t_sleep;
		t_critical;
		tally_and_finish;
	end
endmodule : tb_top
`default_nettype wire
